// *** src/ee_pkg.sv ***
package ee_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] DEV_ID = 4'ha;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] LAST_OFF = 4'hf;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_W = PAGE_W + BYTE_BITS;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned WR_TIME_US = 5000;
  localparam int unsigned WR_CYCLES = WR_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RACK, ST_TX, ST_MACK, ST_WAIT} ee_bus_t;
  typedef enum logic [1:0] {K_SADDR, K_WADDR, K_DATA} ee_kind_t;
  typedef enum logic [1:0] {PG_IDLE, PG_LOAD, PG_WAIT, PG_DRAIN} ee_pg_t;
endpackage

// *** src/ee_slave.sv ***
`timescale 1ns/1ns
module ee_fifo #(
  parameter int unsigned W = 12,
  parameter int unsigned D = 16
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // not full
  input wire logic [W-1:0] in_data_i, // write word
  output logic out_valid_o, // not empty
  input wire logic out_ready_i, // read accept
  output logic [W-1:0] out_data_o // head word
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] buf_reg [D];
  logic [W-1:0] buf_next [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic wr, rd;

  assign in_ready_o = cnt_reg != D[AW:0];
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = buf_reg[rp_reg];

  always_comb begin
    buf_next = buf_reg;
    wr = in_valid_i && in_ready_o;
    rd = out_valid_o && out_ready_i;
    wp_next = wr ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next = rd ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg;
    if (wr) begin
      buf_next[wp_reg] = in_data_i;
    end
    if (wr && !rd) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (rd && !wr) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (ce_i) begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      buf_reg <= buf_next;
    end
  end
endmodule

`timescale 1ns/1ns
module ee_slave import ee_pkg::*; #(
  parameter int unsigned WR_CYC = WR_CYCLES
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic ce_i, // clock enable
  input wire logic scl_i, // bus clock pin
  input wire logic sda_i, // bus data pin level
  output logic sda_o, // data pin drive value
  output logic sda_oe_o, // data pin pull low
  input wire logic wp_i, // write protect
  input wire logic sup_rst_i, // supervisor reset, high
  output logic busy_o // programming in progress
);
  logic [2:0] scl_q, sda_q;
  logic [1:0] wp_q, sup_q;
  logic scl_s, sda_s, wp_s, sup_s, scl_rise, scl_fall, start_det, stop_det;
  ee_bus_t st_reg, st_next;
  ee_kind_t kind_reg, kind_next;
  ee_pg_t pg_reg, pg_next;
  logic [3:0] cnt_reg, cnt_next, idx_reg, idx_next, base_reg, base_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next, addr_reg, addr_next;
  logic [7:0] pbuf_reg [PAGE_BYTES];
  logic [7:0] pbuf_next [PAGE_BYTES];
  logic [7:0] mem_reg [MEM_BYTES];
  logic [7:0] mem_next [MEM_BYTES];
  logic [PAGE_BYTES-1:0] pval_reg, pval_next;
  logic [31:0] tmr_reg, tmr_next;
  logic oe_reg, oe_next, rd_reg, rd_next, ackd_reg, ackd_next, pend_reg, pend_next;
  logic busy_reg, ld, go, push, pop, f_in_rdy, f_out_vld, load_last;
  logic [FIFO_W-1:0] f_out;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      wp_q <= 2'h0;
      sup_q <= 2'h0;
    end else if (ce_i) begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      wp_q <= {wp_q[0], wp_i};
      sup_q <= {sup_q[0], sup_rst_i};
    end
  end

  assign scl_s = scl_q[1];
  assign sda_s = sda_q[1];
  assign wp_s = wp_q[1];
  assign sup_s = sup_q[1];
  assign scl_rise = scl_s && !scl_q[2];
  assign scl_fall = !scl_s && scl_q[2];
  assign start_det = scl_s && scl_q[2] && sda_q[2] && !sda_s;
  assign stop_det = scl_s && scl_q[2] && !sda_q[2] && sda_s;
  assign load_last = pg_reg == PG_LOAD && idx_reg == LAST_OFF && (f_in_rdy || !pval_reg[idx_reg]);

  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    ackd_next = ackd_reg;
    pend_next = pend_reg;
    pbuf_next = pbuf_reg;
    pval_next = load_last ? '0 : pval_reg;
    ld = 1'b0;
    go = 1'b0;
    if (sup_s) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
      pend_next = 1'b0;
    end else if (stop_det) begin
      go = pend_reg;
      pend_next = 1'b0;
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start_det) begin
      st_next = ST_RX;
      kind_next = K_SADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        ST_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == LAST_BIT) begin
            st_next = ST_RACK;
            oe_next = 1'b1;
            case (kind_reg)
              K_SADDR: begin
                if (sh_reg[7:4] == DEV_ID && !busy_reg) begin
                  rd_next = sh_reg[0];
                  kind_next = K_WADDR;
                end else begin
                  st_next = ST_WAIT;
                  oe_next = 1'b0;
                end
              end
              K_WADDR: begin
                addr_next = sh_reg;
                kind_next = K_DATA;
              end
              default: begin
                if (wp_s) begin
                  st_next = ST_WAIT;
                  oe_next = 1'b0;
                  pend_next = 1'b0;
                end else begin
                  pbuf_next[addr_reg[3:0]] = sh_reg;
                  pval_next[addr_reg[3:0]] = 1'b1;
                  pend_next = 1'b1;
                  addr_next = {addr_reg[7:4], addr_reg[3:0] + 4'h1};
                end
              end
            endcase
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            if (rd_reg) begin
              ld = 1'b1;
            end else begin
              st_next = ST_RX;
              cnt_next = 4'h0;
              oe_next = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == LAST_BIT) begin
              st_next = ST_MACK;
              oe_next = 1'b0;
            end else begin
              oe_next = !tx_reg[7];
              tx_next = {tx_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ackd_next = !sda_s;
          end else if (scl_fall) begin
            if (ackd_reg) begin
              ld = 1'b1;
            end else begin
              st_next = ST_WAIT;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (ld) begin
      st_next = ST_TX;
      oe_next = !mem_reg[addr_reg][7];
      tx_next = {mem_reg[addr_reg][6:0], 1'b0};
      cnt_next = 4'h1;
      addr_next = addr_reg + 8'h01;
    end
  end

  always_comb begin
    pg_next = pg_reg;
    idx_next = idx_reg;
    base_next = base_reg;
    tmr_next = tmr_reg;
    mem_next = mem_reg;
    push = 1'b0;
    pop = 1'b0;
    case (pg_reg)
      PG_IDLE: begin
        if (go) begin
          pg_next = PG_LOAD;
          idx_next = 4'h0;
          base_next = addr_reg[7:4];
        end
      end
      PG_LOAD: begin
        push = pval_reg[idx_reg];
        if (f_in_rdy || !pval_reg[idx_reg]) begin
          idx_next = idx_reg + 4'h1;
          if (idx_reg == LAST_OFF) begin
            pg_next = PG_WAIT;
            tmr_next = 32'h0;
          end
        end
      end
      PG_WAIT: begin
        tmr_next = tmr_reg + 32'h1;
        if (tmr_reg == WR_CYC - 1) begin
          pg_next = PG_DRAIN;
        end
      end
      default: begin
        pop = f_out_vld;
        if (f_out_vld) begin
          mem_next[{base_reg, f_out[11:8]}] = f_out[7:0];
        end else begin
          pg_next = PG_IDLE;
        end
      end
    endcase
  end

  ee_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_ready_o(f_in_rdy),
    .in_data_i({idx_reg, pbuf_reg[idx_reg]}),
    .out_valid_o(f_out_vld),
    .out_ready_i(pop),
    .out_data_o(f_out)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      kind_reg <= K_SADDR;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      addr_reg <= 8'h00;
      oe_reg <= 1'b0;
      rd_reg <= 1'b0;
      ackd_reg <= 1'b0;
      pend_reg <= 1'b0;
      pval_reg <= '0;
      pg_reg <= PG_IDLE;
      idx_reg <= 4'h0;
      base_reg <= 4'h0;
      tmr_reg <= 32'h0;
      busy_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      ackd_reg <= ackd_next;
      pend_reg <= pend_next;
      pval_reg <= pval_next;
      pbuf_reg <= pbuf_next;
      pg_reg <= pg_next;
      idx_reg <= idx_next;
      base_reg <= base_next;
      tmr_reg <= tmr_next;
      busy_reg <= pg_next != PG_IDLE;
    end
  end

  // array is non-volatile, so reset leaves it alone
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      mem_reg <= mem_next;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign busy_o = busy_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rx_done;
    ce_i && !sup_s && st_reg == ST_RX && scl_fall && cnt_reg == LAST_BIT;
  endsequence
  sequence s_ack_out;
    sda_oe_o && st_reg == ST_RACK;
  endsequence

  a_start_arm: assert property (ce_i && start_det && !sup_s |=>
    st_reg == ST_RX && cnt_reg == 4'h0 && kind_reg == K_SADDR) else $error("start not armed");
  a_addr_ack: assert property (s_rx_done ##0 (kind_reg == K_SADDR && sh_reg[7:4] == DEV_ID && !busy_reg)
    |=> s_ack_out) else $error("address match not acked");
  a_busy_nack: assert property (s_rx_done ##0 (kind_reg == K_SADDR && busy_reg)
    |=> st_reg == ST_WAIT && !sda_oe_o) else $error("acked while programming");
  a_waddr_ack: assert property (s_rx_done ##0 (kind_reg == K_WADDR)
    |=> s_ack_out ##0 addr_reg == $past(sh_reg)) else $error("word address not acked");
  a_wp_block: assert property (s_rx_done ##0 (kind_reg == K_DATA && wp_s)
    |=> st_reg == ST_WAIT && !sda_oe_o && !pend_reg) else $error("protected byte acked");
  a_page_wrap: assert property (s_rx_done ##0 (kind_reg == K_DATA && !wp_s)
    |=> addr_reg[7:4] == $past(addr_reg[7:4]) && addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1)
    else $error("page offset wrong");
  a_read_incr: assert property (ce_i && ld |=>
    addr_reg == $past(addr_reg) + 8'h01 && st_reg == ST_TX) else $error("read counter wrong");
  a_mack_free: assert property (st_reg == ST_MACK |-> !sda_oe_o) else $error("line held in ack slot");
  a_prog_start: assert property (ce_i && stop_det && !sup_s && pend_reg && pg_reg == PG_IDLE
    |=> pg_reg == PG_LOAD ##1 busy_o) else $error("programming not started");
  a_no_empty: assert property (ce_i && stop_det && !pend_reg && pg_reg == PG_IDLE
    |=> pg_reg == PG_IDLE) else $error("empty write programmed");
  a_sup_abort: assert property (ce_i && sup_s |=>
    st_reg == ST_IDLE && !sda_oe_o && !pend_reg) else $error("supervisor reset ignored");
endmodule

// *** testbench/ee_master_model.sv ***
`timescale 1ns/1ns
module ee_master_model (
  input wire logic clk_i, // system clock
  input wire logic sda_i, // resolved data wire
  output logic scl_o, // bus clock, high when idle
  output logic pull_o // high pulls data low
);
  localparam int H = 16;
  initial begin
    scl_o = 1'h1;
    pull_o = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // data moves only while clock low
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    pull_o <= ~b;
    tick(H - 2);
    scl_o <= 1'h1;
    tick(H);
    r = sda_i;
    scl_o <= 1'h0;
  endtask
  task automatic start();
    tick(2);
    pull_o <= 1'h0;
    tick(H);
    scl_o <= 1'h1;
    tick(H);
    pull_o <= 1'h1;
    tick(H);
    scl_o <= 1'h0;
  endtask
  task automatic stop();
    tick(2);
    pull_o <= 1'h1;
    tick(H);
    scl_o <= 1'h1;
    tick(H);
    pull_o <= 1'h0;
    tick(H);
  endtask
  // bytes msb first, ack slot released
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'h1, r);
    ack = ~r;
  endtask
  // master acks all but the last byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'h1, r);
      d = {d[6:0], r};
    end
    bit_x(~ack, r);
  endtask
endmodule

// *** testbench/tb_ee_slave.sv ***
`timescale 1ns/1ns
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end
module tb_ee_slave;
  import ee_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wp_i = 1'h0;
  logic sup_rst_i = 1'h0;
  logic sda_o, sda_oe_o, busy_o, a;
  logic [7:0] d;
  logic [7:0] ex [16];
  wire scl, pull;
  wire sda = ~(sda_oe_o | pull);
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 clk_i = ~clk_i;
  ee_slave #(.WR_CYC(2000)) u_ee_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i), .sup_rst_i(sup_rst_i), .busy_o(busy_o));
  ee_master_model u_ee_master_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic wb(input logic [7:0] v, input logic exp);
    u_ee_master_model.wr_byte(v, a);
    `CHK("ack", exp, a);
  endtask
  task automatic wr_addr(input logic [7:0] wa);
    u_ee_master_model.start();
    wb(8'ha0, 1'h1);
    wb(wa, 1'h1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy_o !== 1'h0; i++) @(posedge clk_i);
    `CHK("busy", 1'h0, busy_o);
  endtask
  task automatic rd_seq(input int n);
    for (int i = 0; i < n; i++) begin
      u_ee_master_model.rd_byte(i < n - 1, d);
      `CHK("rdata", ex[i], d);
    end
    u_ee_master_model.tick(8);
    `CHK("release", 1'h0, sda_oe_o);
    `CHK("drive", 1'h0, sda_o);
    u_ee_master_model.stop();
  endtask
  task automatic rnd_read(input logic [7:0] wa, input int n);
    wr_addr(wa);
    u_ee_master_model.start();
    wb(8'ha1, 1'h1);
    rd_seq(n);
  endtask
  task automatic t_byte_poll();
    wr_addr(8'h05);
    wb(8'h3c, 1'h1);
    u_ee_master_model.stop();
    `CHK("busy", 1'h1, busy_o);
    u_ee_master_model.start();
    wb(8'ha0, 1'h0);
    u_ee_master_model.stop();
    wait_idle();
    u_ee_master_model.start();
    wb(8'ha0, 1'h1);
    u_ee_master_model.stop();
    ex[0] = 8'h3c;
    rnd_read(8'h05, 1);
  endtask
  task automatic t_page_wrap();
    wr_addr(8'h10);
    for (int i = 0; i < 17; i++) wb(8'h40 + 8'(i), 1'h1);
    u_ee_master_model.stop();
    wait_idle();
    for (int i = 0; i < 16; i++) ex[i] = 8'h40 + 8'(i);
    ex[0] = 8'h50;
    rnd_read(8'h10, 16);
  endtask
  task automatic t_wrap_top();
    wr_addr(8'hfe);
    wb(8'hfe, 1'h1);
    wb(8'hff, 1'h1);
    u_ee_master_model.stop();
    wait_idle();
    wr_addr(8'h00);
    wb(8'h77, 1'h1);
    u_ee_master_model.stop();
    wait_idle();
    ex[0] = 8'hfe;
    ex[1] = 8'hff;
    rnd_read(8'hfe, 2);
    u_ee_master_model.start();
    wb(8'ha1, 1'h1);
    ex[0] = 8'h77;
    rd_seq(1);
  endtask
  task automatic t_protect();
    wp_i <= 1'h1;
    wr_addr(8'h11);
    wb(8'h99, 1'h0);
    u_ee_master_model.stop();
    `CHK("busy", 1'h0, busy_o);
    wp_i <= 1'h0;
    ex[0] = 8'h41;
    rnd_read(8'h11, 1);
  endtask
  task automatic t_refuse();
    wr_addr(8'h20);
    u_ee_master_model.stop();
    `CHK("busy", 1'h0, busy_o);
    u_ee_master_model.start();
    wb(8'hb0, 1'h0);
    u_ee_master_model.stop();
    wb(8'ha0, 1'h0);
  endtask
  task automatic t_sup();
    u_ee_master_model.start();
    wb(8'ha0, 1'h1);
    sup_rst_i <= 1'h1;
    wb(8'h20, 1'h0);
    u_ee_master_model.stop();
    u_ee_master_model.start();
    wb(8'ha0, 1'h0);
    u_ee_master_model.stop();
    sup_rst_i <= 1'h0;
    u_ee_master_model.tick(8);
    u_ee_master_model.start();
    wb(8'ha0, 1'h1);
    u_ee_master_model.stop();
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    t_byte_poll();
    t_page_wrap();
    t_wrap_top();
    t_protect();
    t_refuse();
    t_sup();
    finish_test();
  end
endmodule
